// file: logic/qpc_defs.svh
// register offsets, field positions, reset values and sizes of the qos classifier
// assumes: included by bare name from the package and the design files
`ifndef QPC_DEFS_SVH
`define QPC_DEFS_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define QPC_OFS_CTRL     8'h00
`define QPC_OFS_PCP_MAP  8'h04
`define QPC_OFS_DSCP_LO  8'h08
`define QPC_OFS_DSCP_HI  8'h0c
`define QPC_OFS_QSTAT    8'h10
`define QPC_OFS_DROPS    8'h14

// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define QPC_CTRL_MODE_LSB  0
`define QPC_CTRL_WRR_BIT   2
`define QPC_CTRL_JUMBO_BIT 3
`define QPC_CTRL_BULK_LSB  4
`define QPC_CTRL_WHI_LSB   8
`define QPC_CTRL_WLO_LSB   12

// ------------------------------------------------------------
// reset values and sizes
// ------------------------------------------------------------
`define QPC_PCP_MAP_RST  8'h00
`define QPC_DSCP_MAP_RST 64'h0
`define QPC_WT_HI_RST    4'h3
`define QPC_WT_LO_RST    4'h1
`define QPC_DEPTH        16
`define QPC_NORM_THR     12

`endif

// file: logic/qpc_pkg.sv
// types shared by the qos classifier and its egress scheduler
// assumes: qpc_defs.svh lies on the include path
package qpc_pkg;
   `include "qpc_defs.svh"

   typedef enum logic [1:0] {
      QPC_OFF  = 2'h0,
      QPC_PCP  = 2'h1,
      QPC_DSCP = 2'h2
   } qpc_mode_t;

   typedef enum logic [1:0] {
      QPC_BULK_KEEP = 2'h0,
      QPC_BULK_NORM = 2'h1,
      QPC_BULK_HIGH = 2'h2
   } qpc_bulk_t;

   // header fields of one received frame, extracted upstream
   typedef struct packed {
      logic has_tag;
      logic [2:0] pcp;
      logic is_ip;
      logic [5:0] dscp;
      logic [7:0] tag;
   } qpc_desc_t;

   typedef struct packed {
      logic high;
      logic drop;
      logic [7:0] tag;
   } qpc_res_t;
endpackage

// file: logic/qpc_sched.sv
// egress pick between the high and normal queues: strict or weighted round robin
// assumes: same clock as the classifier; take pulses once per dequeued packet
`timescale 1ns/10ps
module qpc_sched
   import qpc_pkg::*;
(
   input logic pclk,
   input logic presetn,
   input logic pce,
   input logic hi_avail,
   input logic lo_avail,
   input logic wrr_en,
   input logic [3:0] wt_hi,
   input logic [3:0] wt_lo,
   input logic take,
   output logic sel_hi
);
   logic turn_hi_q;
   logic turn_hi_d;
   logic [3:0] credit_q;
   logic [3:0] credit_d;
   logic [4:0] credit_inc;
   logic [3:0] wt_cur;
   logic [3:0] wt_sel;
   logic wrr_pick;

   assign wt_cur = turn_hi_q ? wt_hi : wt_lo;
   assign wt_sel = sel_hi ? wt_hi : wt_lo;
   assign credit_inc = {1'b0, credit_q} + 5'h01;
   // an empty turn owner yields so the other queue never idles
   assign wrr_pick = (hi_avail && lo_avail) ? turn_hi_q : hi_avail;
   assign sel_hi = wrr_en ? wrr_pick : hi_avail; // R6 R8

   always_comb begin
      turn_hi_d = turn_hi_q;
      credit_d = credit_q;
      if (take && wrr_en) begin
         if (sel_hi != turn_hi_q) begin
            // a weight of one is used up by this single yielded frame
            if (wt_sel <= 4'h1) begin
               turn_hi_d = turn_hi_q;
               credit_d = 4'h0;
            end else begin
               turn_hi_d = sel_hi;
               credit_d = 4'h1;
            end
         end else if (credit_inc >= {1'b0, wt_cur}) begin
            // weight zero behaves as one
            turn_hi_d = ~turn_hi_q;
            credit_d = 4'h0;
         end else begin
            credit_d = credit_inc[3:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         turn_hi_q <= 1'b1;
         credit_q <= 4'h0;
      end else if (pce) begin
         turn_hi_q <= turn_hi_d;
         credit_q <= credit_d;
      end
   end
endmodule

// file: logic/qpc_top.sv
// qos priority classifier: per-frame class, congestion drop and egress pick
// assumes: apb master on pclk; descriptors and egress ready come from logic on pclk
//
// Notes on behaviour
// [R1] three exclusive modes: off, user priority, code point; one decides at a time
// [R2] with classification off every frame gets the same, normal, class
// [R3] user priority mode indexes an eight-entry high/normal table by tag priority
// [R4] code point mode indexes a 64-entry high/normal table by six-bit code point
// [R5] two classes; under load normal frames are dropped before high ones
// [R6] in strict mode high class frames are served ahead of normal ones at egress
// [R7] bulk setting fills active table all normal or all high; custom writes entries
// [R8] strict or weighted round robin; round robin barred while jumbo frames enabled
// [R9] frame lacking the field the mode needs gets normal class
`timescale 1ns/10ps
`include "qpc_defs.svh"
module qpc_top
   import qpc_pkg::*;
#(
   parameter int DEPTH = `QPC_DEPTH,
   parameter int NORM_THR = `QPC_NORM_THR
) (
   input logic pclk,
   input logic presetn,
   input logic pce,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input logic rx_valid,
   input qpc_desc_t rx_desc,
   output logic rx_ready,
   output logic res_valid,
   output qpc_res_t res,
   input logic tx_ready,
   output logic tx_valid,
   output logic tx_high
);
   localparam int CW = $clog2(DEPTH + 1);

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rd_mux;
   logic hit_ctrl;
   logic hit_pcp;
   logic hit_dlo;
   logic hit_dhi;
   logic hit_qst;
   logic hit_drp;
   logic addr_hit;
   logic acc_first;
   logic wr_en;

   assign hit_ctrl = paddr == `QPC_OFS_CTRL;
   assign hit_pcp = paddr == `QPC_OFS_PCP_MAP;
   assign hit_dlo = paddr == `QPC_OFS_DSCP_LO;
   assign hit_dhi = paddr == `QPC_OFS_DSCP_HI;
   assign hit_qst = paddr == `QPC_OFS_QSTAT;
   assign hit_drp = paddr == `QPC_OFS_DROPS;
   assign addr_hit = hit_ctrl | hit_pcp | hit_dlo | hit_dhi | hit_qst | hit_drp;
   assign acc_first = psel && penable && !pready_q;
   // writes land on the completing edge; unmapped writes are dropped
   assign wr_en = pce && psel && penable && pready_q && pwrite && addr_hit;

   // ------------------------------------------------------------
   // configuration
   // ------------------------------------------------------------
   qpc_mode_t mode_q;
   logic wrr_q;
   logic jumbo_q;
   logic [3:0] wt_hi_q;
   logic [3:0] wt_lo_q;
   logic [7:0] pcp_map_q;
   logic [63:0] dscp_map_q;
   logic [1:0] wr_mode;
   qpc_mode_t mode_d;
   qpc_bulk_t bulk_w;
   logic jumbo_d;
   logic wrr_d;
   logic bulk_pcp;
   logic bulk_dscp;
   logic bulk_val;
   logic [7:0] pcp_map_d;
   logic [63:0] dscp_map_d;

   assign wr_mode = pwdata[`QPC_CTRL_MODE_LSB +: 2];
   // the unused fourth code is refused and the old mode kept
   assign mode_d = (wr_mode == 2'h3) ? mode_q : qpc_mode_t'(wr_mode); // R1
   assign jumbo_d = pwdata[`QPC_CTRL_JUMBO_BIT];
   assign wrr_d = pwdata[`QPC_CTRL_WRR_BIT] && !jumbo_d; // R8
   assign bulk_w = qpc_bulk_t'(pwdata[`QPC_CTRL_BULK_LSB +: 2]);
   assign bulk_val = bulk_w == QPC_BULK_HIGH;
   // bulk fill targets the table of the mode in force after the write
   assign bulk_pcp = wr_en && hit_ctrl && mode_d == QPC_PCP && bulk_w != QPC_BULK_KEEP; // R7
   assign bulk_dscp = wr_en && hit_ctrl && mode_d == QPC_DSCP && bulk_w != QPC_BULK_KEEP; // R7
   assign pcp_map_d = bulk_pcp ? {8{bulk_val}} : pwdata[7:0]; // R7
   assign dscp_map_d = bulk_dscp ? {64{bulk_val}} :
      (hit_dlo ? {dscp_map_q[63:32], pwdata} : {pwdata, dscp_map_q[31:0]}); // R7

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= QPC_OFF;
         wrr_q <= 1'b0;
         jumbo_q <= 1'b0;
         wt_hi_q <= `QPC_WT_HI_RST;
         wt_lo_q <= `QPC_WT_LO_RST;
      end else if (wr_en && hit_ctrl) begin
         mode_q <= mode_d;
         wrr_q <= wrr_d;
         jumbo_q <= jumbo_d;
         wt_hi_q <= pwdata[`QPC_CTRL_WHI_LSB +: 4];
         wt_lo_q <= pwdata[`QPC_CTRL_WLO_LSB +: 4];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcp_map_q <= `QPC_PCP_MAP_RST;
         dscp_map_q <= `QPC_DSCP_MAP_RST;
      end else begin
         if (bulk_pcp || (wr_en && hit_pcp)) begin
            pcp_map_q <= pcp_map_d;
         end
         if (bulk_dscp || (wr_en && (hit_dlo || hit_dhi))) begin
            dscp_map_q <= dscp_map_d;
         end
      end
   end

   // ------------------------------------------------------------
   // classification and congestion drop
   // ------------------------------------------------------------
   logic rx_ready_q;
   logic res_valid_q;
   qpc_res_t res_q;
   logic acc;
   logic cls_high;
   logic cls_drop;
   logic [CW-1:0] cnt_hi_q;
   logic [CW-1:0] cnt_lo_q;
   logic [CW:0] total;
   logic pcp_high;
   logic dscp_high;

   assign acc = pce && rx_valid && rx_ready_q;
   assign pcp_high = rx_desc.has_tag && pcp_map_q[rx_desc.pcp]; // R3 R9
   assign dscp_high = rx_desc.is_ip && dscp_map_q[rx_desc.dscp]; // R4 R9
   // only the selected table is consulted; off means all normal
   assign cls_high = (mode_q == QPC_PCP) ? pcp_high : (mode_q == QPC_DSCP) ? dscp_high : 1'b0; // R1 R2
   assign total = {1'b0, cnt_hi_q} + {1'b0, cnt_lo_q};
   // normal frames give up the last DEPTH-NORM_THR slots to high frames
   assign cls_drop = cls_high ? (total >= (CW+1)'(DEPTH)) : (total >= (CW+1)'(NORM_THR)); // R5

   // ------------------------------------------------------------
   // egress queues and pick
   // ------------------------------------------------------------
   logic tx_valid_q;
   logic tx_high_q;
   logic hi_avail;
   logic lo_avail;
   logic sel_hi;
   logic deq;
   logic deq_hi;
   logic deq_lo;
   logic enq_hi;
   logic enq_lo;
   logic [15:0] drop_lo_q;
   logic [15:0] drop_hi_q;

   assign hi_avail = cnt_hi_q != '0;
   assign lo_avail = cnt_lo_q != '0;
   assign deq = pce && tx_ready && (hi_avail || lo_avail);
   assign deq_hi = deq && sel_hi; // R6
   assign deq_lo = deq && !sel_hi;
   assign enq_hi = acc && cls_high && !cls_drop;
   assign enq_lo = acc && !cls_high && !cls_drop;

   qpc_sched u_sched (
      .pclk(pclk),
      .presetn(presetn),
      .pce(pce),
      .hi_avail(hi_avail),
      .lo_avail(lo_avail),
      .wrr_en(wrr_q),
      .wt_hi(wt_hi_q),
      .wt_lo(wt_lo_q),
      .take(deq),
      .sel_hi(sel_hi)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_ready_q <= 1'b0;
         res_valid_q <= 1'b0;
         res_q <= '0;
         cnt_hi_q <= '0;
         cnt_lo_q <= '0;
         tx_valid_q <= 1'b0;
         tx_high_q <= 1'b0;
         drop_lo_q <= 16'h0000;
         drop_hi_q <= 16'h0000;
      end else if (pce) begin
         rx_ready_q <= 1'b1;
         res_valid_q <= acc;
         if (acc) begin
            res_q <= '{high: cls_high, drop: cls_drop, tag: rx_desc.tag};
         end
         cnt_hi_q <= cnt_hi_q + CW'(enq_hi) - CW'(deq_hi);
         cnt_lo_q <= cnt_lo_q + CW'(enq_lo) - CW'(deq_lo);
         tx_valid_q <= deq;
         tx_high_q <= deq_hi;
         // counters saturate rather than wrap
         if (acc && cls_drop && !cls_high && drop_lo_q != 16'hffff) begin
            drop_lo_q <= drop_lo_q + 16'h0001;
         end
         if (acc && cls_drop && cls_high && drop_hi_q != 16'hffff) begin
            drop_hi_q <= drop_hi_q + 16'h0001;
         end
      end
   end

   // ------------------------------------------------------------
   // read back and bus answer
   // ------------------------------------------------------------
   assign rd_mux = hit_ctrl ? {16'h0000, wt_lo_q, wt_hi_q, 4'h0, jumbo_q, wrr_q, mode_q} :
                   hit_pcp ? {24'h000000, pcp_map_q} :
                   hit_dlo ? dscp_map_q[31:0] :
                   hit_dhi ? dscp_map_q[63:32] :
                   hit_qst ? {8'h00, 8'(cnt_lo_q), 8'h00, 8'(cnt_hi_q)} :
                   hit_drp ? {drop_hi_q, drop_lo_q} : 32'h00000000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else if (pce) begin
         pready_q <= acc_first;
         pslverr_q <= acc_first && !addr_hit;
         prdata_q <= (acc_first && !pwrite) ? rd_mux : 32'h00000000;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign rx_ready = rx_ready_q;
   assign res_valid = res_valid_q;
   assign res = res_q;
   assign tx_valid = tx_valid_q;
   assign tx_high = tx_high_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_mode_legal: assert property (mode_q != qpc_mode_t'(2'h3)) // R1
      else $error("illegal classification mode held");
   chk_off_normal: assert property (acc && mode_q == QPC_OFF |=> res_valid_q && !res_q.high) // R2
      else $error("frame classed high with classification off");
   chk_pcp_lookup: assert property (acc && mode_q == QPC_PCP && rx_desc.has_tag |=>
      res_q.high == $past(pcp_high)) // R3
      else $error("user priority lookup mismatch");
   chk_dscp_lookup: assert property (acc && mode_q == QPC_DSCP && rx_desc.is_ip && dscp_map_q[rx_desc.dscp]
      |=> res_valid_q && res_q.high) // R4
      else $error("code point lookup mismatch");
   chk_missing_field: assert property (acc && ((mode_q == QPC_PCP && !rx_desc.has_tag) ||
      (mode_q == QPC_DSCP && !rx_desc.is_ip)) |=> !res_q.high) // R9
      else $error("frame without field classed high");
   chk_high_kept: assert property (acc && cls_high && total < (CW+1)'(DEPTH) |=> !res_q.drop) // R5
      else $error("high frame dropped while room remained");
   chk_norm_drop: assert property (acc && !cls_high && total >= (CW+1)'(NORM_THR) |=> res_q.drop) // R5
      else $error("normal frame kept above threshold");
   chk_strict_first: assert property (pce && !wrr_q && tx_ready && hi_avail |=> tx_valid_q && tx_high_q) // R6
      else $error("strict mode served normal while high waited");
   chk_wrr_barred: assert property (jumbo_q |-> !wrr_q) // R8
      else $error("round robin active with jumbo frames");
   chk_bulk_high: assert property (bulk_pcp && bulk_val |=> pcp_map_q == 8'hff ##1 pcp_map_q == 8'hff
      || $past(wr_en)) // R7
      else $error("bulk high fill of user priority table failed");

   cov_high_frame: cover property (acc && cls_high ##1 res_valid_q && res_q.high);
   cov_norm_drop: cover property (acc && !cls_high && cls_drop);
   cov_wrr_low: cover property (wrr_q && deq_lo && hi_avail);
   cov_bulk_dscp: cover property (bulk_dscp && bulk_val);
endmodule

// file: test/qpc_peer.sv
// egress side model: takes frames when not stalled and tallies their class
// assumes: shares pclk and presetn with qpc_top
`timescale 1ns/10ps
module qpc_peer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic stall,
   input wire logic clr,
   input wire logic tx_valid,
   input wire logic tx_high,
   output logic tx_ready,
   output logic [7:0] n_hi,
   output logic [7:0] n_lo,
   output logic late_hi
);
   // late_hi: a high frame seen after a normal one since the last clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ready <= 1'b0;
         n_hi <= 8'h00;
         n_lo <= 8'h00;
         late_hi <= 1'b0;
      end else if (clr) begin
         n_hi <= 8'h00;
         n_lo <= 8'h00;
         late_hi <= 1'b0;
      end else begin
         tx_ready <= !stall;
         if (tx_valid && tx_high) begin
            n_hi <= n_hi + 8'h01;
            late_hi <= late_hi | (n_lo != 8'h00);
         end else if (tx_valid) begin
            n_lo <= n_lo + 8'h01;
         end
      end
   end
endmodule

// file: test/tb.sv
// self-checking bench for qpc_top: apb setup, random frames, congestion and drain
// assumes: qpc_pkg compiled first, qpc_peer model on the egress side
`timescale 1ns/10ps
module tb;
   import qpc_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, rx_valid = 1'b0, rx_ready, res_valid, tx_ready, tx_valid, tx_high;
   logic stall = 1'b0, clr = 1'b0, late_hi, pce = 1'b1;
   logic [7:0] n_hi, n_lo, pm;
   logic [63:0] dm;
   logic [31:0] r;
   qpc_desc_t rx_desc = '0, d;
   qpc_res_t res;
   int n_mismatch = 0, n_compared = 0, cyc = 0;

   qpc_top u_qpc_top (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_valid(rx_valid), .rx_desc(rx_desc), .rx_ready(rx_ready),
      .res_valid(res_valid), .res(res), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_high(tx_high));
   qpc_peer u_qpc_peer (.pclk(pclk), .presetn(presetn), .stall(stall), .clr(clr), .tx_valid(tx_valid),
      .tx_high(tx_high), .tx_ready(tx_ready), .n_hi(n_hi), .n_lo(n_lo), .late_hi(late_hi));

   always #5 pclk = ~pclk;
   // ------------------------------------------------------------
   // report helpers
   // ------------------------------------------------------------
   task automatic conclude();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   // ------------------------------------------------------------
   // bus and frame tasks
   // ------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk("read data", rd, exp);
   endtask
   function automatic logic exp_hi(input logic [1:0] m, input qpc_desc_t f);
      case (m)
         2'h1: return f.has_tag & pm[f.pcp];
         2'h2: return f.is_ip & dm[f.dscp];
         default: return 1'b0;
      endcase
   endfunction
   task automatic send(input qpc_desc_t f, input logic eh, input logic ed);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_desc <= f;
      @(posedge pclk);
      rx_valid <= 1'b0;
      #1;
      chk("result valid", {31'h0, res_valid}, 32'h1);
      chk("result", {22'h0, res}, {22'h0, eh, ed, f.tag});
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      r = $urandom(32'h9cab4f21);
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      while (rx_ready !== 1'b1) @(posedge pclk);
      rchk(8'h00, 32'h00001300);
      rchk(8'h04, 32'h0);
      rchk(8'h0c, 32'h0);
      rchk(8'h18, 32'h0);
      chk("slave error", {31'h0, err}, 32'h1);
      apb(1'b1, 8'h00, 32'h00001322);
      rchk(8'h0c, 32'hffffffff);
      for (int m = 0; m < 3; m++) begin
         pm = 8'($urandom);
         dm = {$urandom, $urandom};
         apb(1'b1, 8'h04, {24'h0, pm});
         apb(1'b1, 8'h08, dm[31:0]);
         apb(1'b1, 8'h0c, dm[63:32]);
         apb(1'b1, 8'h00, 32'h00001300 | m);
         for (int i = 0; i < 24; i++) begin
            r = $urandom;
            d = r[18:0];
            send(d, exp_hi(2'(m), d), 1'b0);
         end
      end
      apb(1'b1, 8'h00, 32'h0000130d);
      rchk(8'h00, 32'h00001309);
      apb(1'b1, 8'h00, 32'h00001303);
      rchk(8'h00, 32'h00001301);
      stall <= 1'b1;
      apb(1'b1, 8'h00, 32'h00001311);
      rchk(8'h04, 32'h0);
      for (int i = 0; i < 13; i++) begin
         r = $urandom;
         d = r[18:0];
         d.has_tag = 1'b1;
         send(d, 1'b0, i == 12);
      end
      apb(1'b1, 8'h00, 32'h00001321);
      rchk(8'h04, 32'h000000ff);
      for (int i = 0; i < 6; i++) begin
         r = $urandom;
         d = r[18:0];
         d.has_tag = (i != 5);
         send(d, i != 5, i > 3);
      end
      rchk(8'h10, 32'h000c0004);
      rchk(8'h14, 32'h00010002);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      stall <= 1'b0;
      for (int i = 0; i < 100 && n_lo != 8'd12; i++) @(posedge pclk);
      chk("served high", {24'h0, n_hi}, 32'h4);
      chk("served normal", {24'h0, n_lo}, 32'hc);
      chk("high after normal", {31'h0, late_hi}, 32'h0);
      rchk(8'h10, 32'h0);
      // weighted round robin: high weight 2, normal weight 1
      stall <= 1'b1;
      apb(1'b1, 8'h00, 32'h00001205);
      rchk(8'h00, 32'h00001205);
      // frozen core must ignore a descriptor
      pce <= 1'b0;
      rx_valid <= 1'b1;
      @(posedge pclk);
      rx_valid <= 1'b0;
      pce <= 1'b1;
      @(posedge pclk);
      chk("frozen accept", {31'h0, res_valid}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         r = $urandom;
         d = r[18:0];
         d.has_tag = i[0];
         send(d, i[0], 1'b0);
      end
      rchk(8'h10, 32'h00040004);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      stall <= 1'b0;
      for (int i = 0; i < 100 && n_hi + n_lo != 8'd8; i++) @(posedge pclk);
      chk("wrr high", {24'h0, n_hi}, 32'h4);
      chk("wrr normal", {24'h0, n_lo}, 32'h4);
      chk("wrr interleave", {31'h0, late_hi}, 32'h1);
      conclude();
   end
endmodule
